// ### verification/smtb_pcm_mux.sv
// far side model: pcm multiplexer, timing source and speech write receiver
`timescale 1ns/1ps
module smtb_pcm_mux (
   input wire logic clk_sys_i,
   input wire logic fmt_24_i,
   input wire logic hold_i,
   input wire logic stall_i,
   input wire logic slow_i,
   output logic master_timing_o,
   output logic frame_sync_o,
   output logic [smtb_pkg::SMTB_LINKS-1:0] pcm_o,
   output logic ready_o
);
   import smtb_pkg::*;
   // ---------------------------------------------------------------
   // timing and frame position
   // ---------------------------------------------------------------
   logic [3:0] cnt_q = 4'h0;
   logic [8:0] idx_q = 9'h000;
   logic [8:0] last;
   // no framing bit in 24 mode: the 192 bit variant
   assign last = fmt_24_i ? 9'h17f : 9'h1ff;
   always_ff @(posedge clk_sys_i) begin
      if (!hold_i) begin
         cnt_q <= (cnt_q == 4'h9) ? 4'h0 : cnt_q + 4'h1;
         if (cnt_q == 4'h9) begin
            idx_q <= (idx_q == last) ? 9'h000 : idx_q + 9'h001;
         end
      end
   end
   // ten clk per tick stands in for the master rate; hold stops it dead
   assign master_timing_o = (cnt_q >= 4'h5);
   // held high two ticks: only the first may align
   assign frame_sync_o = (idx_q <= 9'h001);
   // ---------------------------------------------------------------
   // links: byte of channel c on link l is {l, c}, msb first
   // ---------------------------------------------------------------
   always_comb begin
      logic [7:0] b;
      b = 8'h00;
      for (int l = 0; l < 8; l++) begin
         b = {3'(l), idx_q[8:4]};
         pcm_o[l] = b[3'd7 - idx_q[3:1]];
      end
   end
   assign ready_o = !stall_i && !(slow_i && cnt_q[0]);
endmodule

// ### verification/tb.sv
// testbench of the switching matrix time base
`timescale 1ns/1ps
module tb;
   import smtb_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic clk_sys_i = 1'b0;
   logic rstn_i = 1'b0;
   logic fmt_24_i = 1'b0;
   logic hold = 1'b0, stall = 1'b0, slow = 1'b0;
   logic master_timing_i, frame_sync_i, sm_wr_ready_i, sm_wr_valid_o, sm_overrun_o, cm_rd_o;
   logic half_slot_phase_o, bit_sample_strobe_o, timing_lost_o;
   logic [SMTB_LINKS-1:0] pcm_in_i, pcm_out_o;
   logic [SMTB_WORD_W-1:0] slot_data_i = 64'h0ff0_0ff0_0ff0_0ff0;
   logic [SMTB_WORD_W-1:0] sm_wr_data_o;
   logic [SMTB_CHAN_W-1:0] sm_wr_addr_o, control_read_counter_o, speech_address_counter_o;
   logic [SMTB_CM_ADDR_W-1:0] cm_rd_addr_o;
   logic [SMTB_PHASE_W-1:0] slot_phase_counter_o;
   logic [7:0] input_ring_phases_o, output_ring_phases_o;
   logic mt_q = 1'b0, fs_q = 1'b0, chk_en = 1'b0;
   logic [2:0] line_q = 3'h0;
   int error_cnt = 0, checks = 0, tick_cnt = 0, fr_cnt = 0;
   int n_stb = 0, n_rd = 0, n_wr = 0, n_ovr = 0, nch = 32;

   smtb_time_base DUT (.clk_sys_i, .rstn_i, .master_timing_i, .frame_sync_i, .fmt_24_i,
      .pcm_in_i, .slot_data_i, .pcm_out_o, .sm_wr_valid_o, .sm_wr_ready_i, .sm_wr_addr_o,
      .sm_wr_data_o, .sm_overrun_o, .cm_rd_o, .cm_rd_addr_o, .half_slot_phase_o,
      .bit_sample_strobe_o, .slot_phase_counter_o, .input_ring_phases_o,
      .output_ring_phases_o, .control_read_counter_o, .speech_address_counter_o,
      .timing_lost_o);
   smtb_pcm_mux far (.clk_sys_i, .fmt_24_i, .hold_i(hold), .stall_i(stall), .slow_i(slow),
      .master_timing_o(master_timing_i), .frame_sync_o(frame_sync_i), .pcm_o(pcm_in_i),
      .ready_o(sm_wr_ready_i));

   initial begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   // ---------------------------------------------------------------
   // helpers and monitors
   // ---------------------------------------------------------------
   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge clk_sys_i) begin
      logic [4:0] nx;
      int ca;
      nx = (32'(sm_wr_addr_o) == nch - 1) ? 5'h00 : sm_wr_addr_o + 5'h01;
      // the read for line 7 leaves just as the counter steps on
      ca = (32'(control_read_counter_o) + ((line_q == 3'h7) ? nch - 1 : 0)) % nch;
      mt_q <= master_timing_i;
      if (master_timing_i && !mt_q) begin
         tick_cnt <= tick_cnt + 1;
         fs_q <= frame_sync_i;
         if (frame_sync_i && !fs_q) fr_cnt <= fr_cnt + 1;
      end
      if (bit_sample_strobe_o) n_stb <= n_stb + 1;
      if (sm_overrun_o) n_ovr <= n_ovr + 1;
      if (cm_rd_o) n_rd <= n_rd + 1;
      if (chk_en && cm_rd_o) begin
         chk(cm_rd_addr_o[7:5] === line_q, "read line");
         chk(32'(cm_rd_addr_o[4:0]) == ca, "read chan");
         line_q <= line_q + 3'h1;
      end
      if (chk_en && sm_wr_valid_o && sm_wr_ready_i) begin
         n_wr <= n_wr + 1;
         // word at address a carries the bytes of channel a plus one
         for (int l = 0; l < 8; l++) chk(sm_wr_data_o[l*8+:8] === {3'(l), nx}, "wr data");
      end
   end

   // counters settle a cycle or two after the tick edge
   task automatic wait_tick;
      int t;
      t = tick_cnt;
      while (tick_cnt == t) @(negedge clk_sys_i);
      repeat (2) @(negedge clk_sys_i);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic do_reset(input logic f);
      logic [4:0] sp;
      sp = f ? SMTB_LAST_CH_24 : SMTB_LAST_CH_32;
      // off the edge, so the monitor never sees a half-changed setup
      @(negedge clk_sys_i);
      chk_en = 1'b0;
      nch = f ? 24 : 32;
      @(posedge clk_sys_i);
      rstn_i <= 1'b0;
      fmt_24_i <= f;
      repeat (10) @(posedge clk_sys_i);
      #1;
      chk(slot_phase_counter_o === 4'h0 && input_ring_phases_o === 8'h01, "rst phase");
      chk(output_ring_phases_o === 8'h01, "rst out ring");
      chk(control_read_counter_o === 5'h01, "rst ctrl");
      chk(speech_address_counter_o === sp, "rst speech");
      chk(sm_wr_valid_o === 1'b0 && timing_lost_o === 1'b0, "rst flags");
      @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      $display("reset test done");
   endtask

   // exp_hi: link levels while the first four bits of each slot go out
   task automatic run_frame(input logic [7:0] exp_hi);
      int f, ph, ch, s, r, bi;
      f = fr_cnt;
      while (fr_cnt == f) @(negedge clk_sys_i);
      repeat (2) @(negedge clk_sys_i);
      s = n_stb;
      r = n_rd;
      for (int k = 0; k <= nch * 16; k++) begin
         if (k > 0) wait_tick;
         ph = k % 16;
         ch = (k / 16) % nch;
         // last bit sent: this tick's for odd phases, the one before for even
         bi = (ph % 2 == 1) ? ph / 2 : (ph / 2 + 7) % 8;
         chk(slot_phase_counter_o === 4'(ph), "phase");
         chk(half_slot_phase_o === ph[3], "half slot");
         chk(input_ring_phases_o === 8'h01 << ph[3:1], "in ring");
         chk(output_ring_phases_o === 8'h01 << ph[3:1], "out ring");
         chk(control_read_counter_o === 5'((ch + 1) % nch), "ctrl");
         chk(speech_address_counter_o === 5'((ch + nch - 1) % nch), "speech");
         if (ph == 0 && k > 0) begin
            chk(n_stb - s == 8 && n_rd - r == 8 && timing_lost_o === 1'b0, "pulses");
            s = n_stb;
            r = n_rd;
         end
         if (k == 16) begin
            line_q = 3'h0;
            chk_en = 1'b1;
         end
         if (k > 32) chk(pcm_out_o === (bi < 4 ? exp_hi : ~exp_hi), "pcm out");
      end
      $display("frame test done");
   endtask

   task automatic t_stall;
      logic [4:0] a;
      int o, w;
      @(posedge clk_sys_i);
      stall <= 1'b1;
      repeat (36) wait_tick;
      a = sm_wr_addr_o;
      o = n_ovr;
      repeat (48) wait_tick;
      chk(sm_wr_valid_o === 1'b1 && sm_wr_addr_o === a, "held word");
      chk(n_ovr - o == 3, "overrun");
      @(posedge clk_sys_i);
      stall <= 1'b0;
      slow <= 1'b1;
      w = n_wr;
      repeat (48) wait_tick;
      // two held words plus one from each of the three slots that close
      chk(n_wr - w == 5, "drain");
      @(posedge clk_sys_i);
      slow <= 1'b0;
      $display("stall test done");
   endtask

   task automatic t_loss;
      @(posedge clk_sys_i);
      hold <= 1'b1;
      repeat (30) @(posedge clk_sys_i);
      chk(timing_lost_o === 1'b1, "loss");
      hold <= 1'b0;
      repeat (40) @(posedge clk_sys_i);
      chk(timing_lost_o === 1'b0, "recover");
      $display("loss test done");
   endtask

   initial begin
      do_reset(1'b0);
      run_frame(8'h55);
      t_stall;
      t_loss;
      @(posedge clk_sys_i);
      slot_data_i <= 64'hf00f_f00f_f00f_f00f;
      do_reset(1'b1);
      run_frame(8'haa);
      report_and_stop;
   end

   initial begin
      #2000000;
      error_cnt++;
      $display("mismatch %0t watchdog expired", $time);
      report_and_stop;
   end
endmodule

// ### verilog/smtb_pair_buf.sv
// small valid/ready buffer for speech memory write words
`timescale 1ns/1ps
module smtb_pair_buf #(
   parameter int unsigned W = 8,
   parameter int unsigned DEPTH = 2
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_q < (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule

// ### verilog/smtb_pkg.sv
// constants of the switching matrix time base
package smtb_pkg;

   // ---------------------------------------------------------------
   // link geometry
   // ---------------------------------------------------------------
   localparam int unsigned SMTB_LINKS = 8;
   localparam int unsigned SMTB_SLOT_BITS = 8;
   localparam int unsigned SMTB_WORD_W = SMTB_LINKS * SMTB_SLOT_BITS;
   localparam int unsigned SMTB_CHAN_W = 5;
   localparam int unsigned SMTB_PHASE_W = 4;
   localparam int unsigned SMTB_CM_ADDR_W = 8;
   localparam int unsigned SMTB_BUF_DEPTH = 2;

   // ---------------------------------------------------------------
   // counter values
   // ---------------------------------------------------------------
   localparam logic [4:0] SMTB_LAST_CH_32 = 5'h1f;
   localparam logic [4:0] SMTB_LAST_CH_24 = 5'h17;
   localparam logic [4:0] SMTB_CH_ZERO = 5'h00;
   localparam logic [4:0] SMTB_CH_ONE = 5'h01;
   localparam logic [3:0] SMTB_PHASE_ZERO = 4'h0;
   localparam logic [3:0] SMTB_PHASE_LAST = 4'hf;
   localparam logic [7:0] SMTB_RING_RESET = 8'h01;
   localparam int unsigned SMTB_HALF_SLOT_BIT = 3;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned SMTB_SYS_PERIOD_PS = 25000;
   localparam int unsigned SMTB_MASTER_LOSS_NS = 488;
   localparam int unsigned SMTB_LOSS_CYC = (SMTB_MASTER_LOSS_NS * 1000) / SMTB_SYS_PERIOD_PS;
   localparam int unsigned SMTB_GAP_W = 5;

endpackage

// ### verilog/smtb_time_base.sv
// time base, ring phases, channel counters and slot conversion
`timescale 1ns/1ps

// Notes on behaviour
// - all timing derives from the 4.096 MHz master input and 8 kHz frame pulse.
// - two ring counters give eight input and eight output ring phases.
// - one resettable counter divides master clock; 244 ns stages build 3.9 us slots.
// - half slot phase splits each slot into interface half and PCM half.
// - control read and speech address counters advance with the slot counter.
// - control read counter holds output channel plus one.
// - speech address counter holds input channel minus one.
// - eight input links and eight output links, 32 channels each.
// - 32-slot frame: slots 0 to 31, eight bits each, 256 bits.
// - 24-channel mode runs eight links of 24 channels.
// - each channel carries one eight-bit sample per 125 us frame.
// - any input channel may reach any output channel without blocking.
// - connections are kept through an eight-bit processor port.
// - bits sampled at 488 ns strobe, slot bytes written with one pulse.
// - second half of each slot reads control store eight times.
module smtb_time_base
   import smtb_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic master_timing_i,
   input wire logic frame_sync_i,
   input wire logic fmt_24_i,
   input wire logic [smtb_pkg::SMTB_LINKS-1:0] pcm_in_i,
   input wire logic [smtb_pkg::SMTB_WORD_W-1:0] slot_data_i,
   output logic [smtb_pkg::SMTB_LINKS-1:0] pcm_out_o,
   output logic sm_wr_valid_o,
   input wire logic sm_wr_ready_i,
   output logic [smtb_pkg::SMTB_CHAN_W-1:0] sm_wr_addr_o,
   output logic [smtb_pkg::SMTB_WORD_W-1:0] sm_wr_data_o,
   output logic sm_overrun_o,
   output logic cm_rd_o,
   output logic [smtb_pkg::SMTB_CM_ADDR_W-1:0] cm_rd_addr_o,
   output logic half_slot_phase_o,
   output logic bit_sample_strobe_o,
   output logic [smtb_pkg::SMTB_PHASE_W-1:0] slot_phase_counter_o,
   output logic [smtb_pkg::SMTB_SLOT_BITS-1:0] input_ring_phases_o,
   output logic [smtb_pkg::SMTB_SLOT_BITS-1:0] output_ring_phases_o,
   output logic [smtb_pkg::SMTB_CHAN_W-1:0] control_read_counter_o,
   output logic [smtb_pkg::SMTB_CHAN_W-1:0] speech_address_counter_o,
   output logic timing_lost_o
);
   import smtb_pkg::*;

   // ---------------------------------------------------------------
   // master tick and frame alignment
   // ---------------------------------------------------------------
   logic master_q;
   logic sync_q;
   logic tick;
   logic frame_start;
   logic slot_end;
   logic [4:0] last_ch;

   // inputs are synchronous, so one register suffices for edge detect
   assign tick = master_timing_i & ~master_q;
   assign frame_start = tick & frame_sync_i & ~sync_q;
   assign last_ch = fmt_24_i ? SMTB_LAST_CH_24 : SMTB_LAST_CH_32;

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         master_q <= 1'b1;
         sync_q <= 1'b0;
      end else begin
         master_q <= master_timing_i;
         if (tick) begin
            sync_q <= frame_sync_i;
         end
      end
   end

   // ---------------------------------------------------------------
   // slot phase counter and channel counter
   // ---------------------------------------------------------------
   logic [3:0] phase_q;
   logic [4:0] chan_q;

   assign slot_end = tick & (phase_q == SMTB_PHASE_LAST);

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         phase_q <= SMTB_PHASE_ZERO;
         chan_q <= SMTB_CH_ZERO;
      end else if (frame_start) begin
         phase_q <= SMTB_PHASE_ZERO;
         chan_q <= SMTB_CH_ZERO;
      end else if (tick) begin
         phase_q <= phase_q + 4'h1;
         if (phase_q == SMTB_PHASE_LAST) begin
            chan_q <= (chan_q >= last_ch) ? SMTB_CH_ZERO : chan_q + 5'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // control read and speech address counters
   // ---------------------------------------------------------------
   logic [4:0] ctrl_q;
   logic [4:0] speech_q;

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         ctrl_q <= SMTB_CH_ONE;
         speech_q <= last_ch;
      end else if (frame_start) begin
         ctrl_q <= SMTB_CH_ONE;
         speech_q <= last_ch;
      end else if (slot_end) begin
         ctrl_q <= (ctrl_q >= last_ch) ? SMTB_CH_ZERO : ctrl_q + 5'h01;
         speech_q <= (speech_q >= last_ch) ? SMTB_CH_ZERO : speech_q + 5'h01;
      end
   end

   // ---------------------------------------------------------------
   // ring counters
   // ---------------------------------------------------------------
   logic [7:0] in_ring_q;
   logic [7:0] out_ring_q;

   // kept as true rings rather than decodes so each phase is glitch free
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i || frame_start) begin
         in_ring_q <= SMTB_RING_RESET;
      end else if (tick && phase_q[0]) begin
         in_ring_q <= {in_ring_q[6:0], in_ring_q[7]};
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i || frame_start) begin
         out_ring_q <= SMTB_RING_RESET;
      end else if (tick && phase_q[0]) begin
         out_ring_q <= {out_ring_q[6:0], out_ring_q[7]};
      end
   end

   // ---------------------------------------------------------------
   // input capture and speech memory write
   // ---------------------------------------------------------------
   logic [SMTB_WORD_W-1:0] cap_q;
   logic push_valid_q;
   logic [SMTB_CHAN_W-1:0] push_addr_q;
   logic [SMTB_WORD_W-1:0] push_word_q;
   logic push_ready;
   logic [SMTB_CHAN_W+SMTB_WORD_W-1:0] buf_out;

   // mid-bit sampling point, first bit of a slot lands in bit 7
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         cap_q <= '0;
      end else if (tick && !phase_q[0]) begin
         for (int l = 0; l < SMTB_LINKS; l++) begin
            for (int b = 0; b < SMTB_SLOT_BITS; b++) begin
               if (in_ring_q[b]) begin
                  cap_q[l*SMTB_SLOT_BITS + SMTB_SLOT_BITS-1-b] <= pcm_in_i[l];
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         push_valid_q <= 1'b0;
         push_addr_q <= '0;
         push_word_q <= '0;
         sm_overrun_o <= 1'b0;
      end else begin
         push_valid_q <= slot_end;
         sm_overrun_o <= push_valid_q & ~push_ready;
         if (slot_end) begin
            push_addr_q <= speech_q;
            push_word_q <= cap_q;
         end
      end
   end

   // two entries ride out a receiver stall of up to two slots
   smtb_pair_buf #(
      .W(SMTB_CHAN_W + SMTB_WORD_W),
      .DEPTH(SMTB_BUF_DEPTH)
   ) u_wr_buf (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .in_valid_i(push_valid_q),
      .in_ready_o(push_ready),
      .in_data_i({push_addr_q, push_word_q}),
      .out_valid_o(sm_wr_valid_o),
      .out_ready_i(sm_wr_ready_i),
      .out_data_o(buf_out)
   );

   assign sm_wr_addr_o = buf_out[SMTB_CHAN_W+SMTB_WORD_W-1:SMTB_WORD_W];
   assign sm_wr_data_o = buf_out[SMTB_WORD_W-1:0];

   // ---------------------------------------------------------------
   // output conversion
   // ---------------------------------------------------------------
   logic [SMTB_WORD_W-1:0] out_word_q;

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         out_word_q <= '0;
      end else if (slot_end) begin
         out_word_q <= slot_data_i; // single transfer per slot
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         pcm_out_o <= '0;
      end else if (tick && !phase_q[0]) begin
         for (int l = 0; l < SMTB_LINKS; l++) begin
            for (int b = 0; b < SMTB_SLOT_BITS; b++) begin
               if (out_ring_q[b]) begin
                  pcm_out_o[l] <= out_word_q[l*SMTB_SLOT_BITS + SMTB_SLOT_BITS-1-b];
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // control store reads and phase outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         cm_rd_o <= 1'b0;
         cm_rd_addr_o <= '0;
         bit_sample_strobe_o <= 1'b0;
      end else begin
         cm_rd_o <= tick & phase_q[SMTB_HALF_SLOT_BIT];
         if (tick && phase_q[SMTB_HALF_SLOT_BIT]) begin
            cm_rd_addr_o <= {phase_q[2:0], ctrl_q};
         end
         bit_sample_strobe_o <= tick & ~phase_q[0];
      end
   end

   assign half_slot_phase_o = phase_q[SMTB_HALF_SLOT_BIT];
   assign slot_phase_counter_o = phase_q;
   assign input_ring_phases_o = in_ring_q;
   assign output_ring_phases_o = out_ring_q;
   assign control_read_counter_o = ctrl_q;
   assign speech_address_counter_o = speech_q;

   // ---------------------------------------------------------------
   // master clock loss watch
   // ---------------------------------------------------------------
   logic [SMTB_GAP_W-1:0] gap_q;

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         gap_q <= '0;
         timing_lost_o <= 1'b0;
      end else if (tick) begin
         gap_q <= '0;
         timing_lost_o <= 1'b0;
      end else begin
         if (gap_q < SMTB_GAP_W'(SMTB_LOSS_CYC)) begin
            gap_q <= gap_q + 1'b1;
         end
         timing_lost_o <= (gap_q >= SMTB_GAP_W'(SMTB_LOSS_CYC));
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   sequence s_slot_close;
      tick && (phase_q == SMTB_PHASE_LAST) && !frame_start;
   endsequence

   sequence s_frame_close;
      s_slot_close ##0 (chan_q == last_ch);
   endsequence

   a_ring_in_onehot: assert property ($onehot(in_ring_q))
      else $error("input ring phases not one-hot");
   a_ring_out_onehot: assert property ($onehot(out_ring_q))
      else $error("output ring phases not one-hot");
   a_ring_tracks_bit: assert property (in_ring_q == (8'h01 << phase_q[3:1]))
      else $error("ring phase not aligned to bit index");
   a_frame_align: assert property (frame_start |=> phase_q == 4'h0 && chan_q == 5'h00)
      else $error("frame pulse did not restart counter");
   a_ctrl_plus_one: assert property (
      ctrl_q == ((chan_q == last_ch) ? 5'h00 : chan_q + 5'h01))
      else $error("control read counter not channel plus one");
   a_speech_minus_one: assert property (
      speech_q == ((chan_q == 5'h00) ? last_ch : chan_q - 5'h01))
      else $error("speech address counter not channel minus one");
   a_frame_wrap: assert property (s_frame_close |=> chan_q == 5'h00)
      else $error("channel counter did not wrap");
   a_slot_write: assert property (s_slot_close |=> push_valid_q ##1 !push_valid_q)
      else $error("slot write pulse missing or too long");
   a_cm_read_half: assert property (cm_rd_o |-> $past(phase_q[3]))
      else $error("control store read outside second half");
   a_half_slot: assert property (
      $rose(half_slot_phase_o) |-> $past(phase_q) == 4'h7 && $past(tick))
      else $error("half slot phase changed at wrong step");

endmodule
